// *** hw/orp_top.sv ***
// output relay and protection control with APB register access
// assumes async pin inputs, a 10 MHz clock and one APB master
`timescale 1ns/1ps
`default_nettype none

module orp_top import orp_pkg::*; #(
    parameter int MS_CYCLES = MS_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // power stage pins
    input wire logic RELAY_OPT_I,
    input wire logic VREG_I,
    input wire logic IREG_I,
    input wire logic OUT_OF_REGULATION_I,
    input wire logic OVTRIP_I,
    input wire logic THERMAL_I,
    input wire logic INHIBIT_I,
    input wire logic [15:0] MEAS_V_I,
    input wire logic [15:0] MEAS_I_I,
    // power stage and relay controls
    output logic POWER_EN_O,
    output logic VZERO_O,
    output logic ISRC_MIN_O,
    output logic RELAY_CLOSE_O,
    output logic RELAY_POL_O,
    // fault line and interrupt
    output logic FAULT_O,
    output logic IRQ_O
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [15:0] mv1;
        logic [15:0] mv2;
        logic [15:0] mi1;
        logic [15:0] mi2;
        logic [15:0] mv3;
        logic [15:0] mvq;
        logic [15:0] mi3;
        logic [15:0] miq;
        logic out_req;
        logic fi_en;
        logic ocp_en;
        logic relay_tgt;
        logic pol_tgt;
        logic relay_act;
        logic pol_act;
        logic pwr_act;
        logic vzero;
        logic imin;
        logic [14:0] delay_ms;
        logic [2:0] linksel;
        logic [3:0] prot;
        logic [14:0] tmr;
        logic [13:0] tick;
        logic [2:0] cond;
        orp_seq_t sq;
        logic [23:0] settle;
        logic [2:0] istat;
        logic [2:0] ien;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic fault;
        logic irq;
    } orp_state_t;

    orp_state_t st_ff;
    orp_state_t nxt_st;

    localparam logic [13:0] TICK_END = 14'(MS_CYCLES - 1);
    localparam logic [23:0] SETTLE_N = 24'(SETTLE_CYCLES - 1);

    // synchronised pin names
    logic opt;
    logic cv_pin;
    logic cc_pin;
    logic out_of_regulation_pin;
    logic ov_pin;
    logic ot_pin;
    logic ri_pin;
    assign {ri_pin, ot_pin, ov_pin, out_of_regulation_pin, cc_pin, cv_pin, opt} = st_ff.s2;

    // ==========================================================
    // linked event picked for the fault line
    function automatic logic link_evt(input logic [2:0] sel,
                                      input logic [2:0] cnd,
                                      input logic [3:0] prt);
        logic e;
        e = 1'b0;
        case (sel)
            LK_SUMMARY_SELECTION_THREE: e = (|prt) | cnd[2];
            LK_IREG: e = cnd[1];
            LK_VREG: e = cnd[0];
            LK_PROT: e = |prt;
            default: e = 1'b0;
        endcase
        return e;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        logic setup;
        logic wr;
        logic hit_ctrl;
        logic hit_relay;
        logic hit_delay;
        logic hit_link;
        logic hit_cmd;
        logic hit_ien;
        logic hit_iclr;
        logic relay_bad;
        logic known;
        logic changed;
        logic clr;
        logic [3:0] trips;
        logic [2:0] ev;
        logic [31:0] rd;
        setup = PSEL_I & ~PENABLE_I;
        wr = PSEL_I & PENABLE_I & st_ff.pready & PWRITE_I;
        // write strobes per register
        hit_ctrl = wr & (PADDR_I == A_CTRL);
        hit_relay = wr & (PADDR_I == A_RELAY);
        hit_delay = wr & (PADDR_I == A_DELAY);
        hit_link = wr & (PADDR_I == A_LINK);
        hit_cmd = wr & (PADDR_I == A_CMD);
        hit_ien = wr & (PADDR_I == A_IEN);
        hit_iclr = wr & (PADDR_I == A_ICLR);
        relay_bad = hit_relay & ~opt;
        changed = hit_ctrl | (hit_relay & opt);
        clr = hit_cmd & PWDATA_I[B_CLR];
        trips = 4'h0;
        ev = 3'h0;
        rd = 32'h0;
        known = 1'b1;
        nxt_st = st_ff;

        // input synchronisers
        nxt_st.s1 = {INHIBIT_I, THERMAL_I, OVTRIP_I, OUT_OF_REGULATION_I, IREG_I,
                     VREG_I, RELAY_OPT_I};
        nxt_st.s2 = st_ff.s1;
        nxt_st.mv1 = MEAS_V_I;
        nxt_st.mv2 = st_ff.mv1;
        nxt_st.mi1 = MEAS_I_I;
        nxt_st.mi2 = st_ff.mi1;

        // hold a word until two synced samples agree
        nxt_st.mv3 = st_ff.mv2;
        nxt_st.mi3 = st_ff.mi2;
        if (st_ff.mv2 == st_ff.mv3) begin
            nxt_st.mvq = st_ff.mv2;
        end
        if (st_ff.mi2 == st_ff.mi3) begin
            nxt_st.miq = st_ff.mi2;
        end

        // output command; relay follows when the option is fitted, unless qualified to stay
        if (hit_ctrl) begin
            nxt_st.out_req = PWDATA_I[B_OUT];
            nxt_st.fi_en = PWDATA_I[B_FIEN];
            nxt_st.ocp_en = PWDATA_I[B_OCPEN];
            if (opt && !PWDATA_I[B_LEAVE]) begin
                nxt_st.relay_tgt = PWDATA_I[B_OUT];
            end
        end
        // relay command, refused without the option
        if (hit_relay && opt) begin
            nxt_st.relay_tgt = PWDATA_I[B_RCLOSE];
            nxt_st.pol_tgt = PWDATA_I[B_RPOL];
        end
        if (relay_bad) begin
            ev[I_CMDERR] = 1'b1;
        end
        if (hit_delay) begin
            nxt_st.delay_ms = PWDATA_I[14:0];
        end
        if (hit_link) begin
            nxt_st.linksel = PWDATA_I[2:0];
        end
        if (hit_ien) begin
            nxt_st.ien = PWDATA_I[2:0];
        end

        // status delay: restart on change, record when expired
        if (changed) begin
            nxt_st.tmr = st_ff.delay_ms;
            nxt_st.tick = 14'h0;
        end else if (st_ff.tmr != 15'h0) begin
            if (st_ff.tick == TICK_END) begin
                nxt_st.tick = 14'h0;
                nxt_st.tmr = st_ff.tmr - 15'h1;
            end else begin
                nxt_st.tick = st_ff.tick + 14'h1;
            end
        end else begin
            nxt_st.cond = {out_of_regulation_pin, cc_pin, cv_pin};
            ev[I_COND] = nxt_st.cond != st_ff.cond;
        end

        // trips: voltage at once, current via delayed state
        trips[0] = ov_pin;
        trips[1] = st_ff.ocp_en & st_ff.cond[1] & st_ff.pwr_act;
        trips[2] = ot_pin;
        trips[3] = ri_pin;
        // new trips win over a clear in the same cycle
        nxt_st.prot = (st_ff.prot & ~{4{clr}}) | trips;
        ev[I_TRIP] = |(trips & ~st_ff.prot);

        // relay sequencer
        case (st_ff.sq)
            SQ_IDLE: begin
                if (st_ff.relay_tgt != st_ff.relay_act ||
                    st_ff.pol_tgt != st_ff.pol_act) begin
                    nxt_st.pwr_act = 1'b0;
                    nxt_st.settle = SETTLE_N;
                    nxt_st.sq = SQ_DOWN;
                end else begin
                    // restored from request once latched trips are cleared
                    nxt_st.pwr_act = st_ff.out_req & ~(|st_ff.prot);
                end
            end
            SQ_DOWN: begin
                nxt_st.pwr_act = 1'b0;
                if (st_ff.settle == 24'h0) begin
                    nxt_st.relay_act = st_ff.relay_tgt;
                    nxt_st.pol_act = st_ff.pol_tgt;
                    nxt_st.settle = SETTLE_N;
                    nxt_st.sq = SQ_MOVE;
                end else begin
                    nxt_st.settle = st_ff.settle - 24'h1;
                end
            end
            SQ_MOVE: begin
                nxt_st.pwr_act = 1'b0;
                if (st_ff.settle == 24'h0) begin
                    nxt_st.sq = SQ_IDLE;
                end else begin
                    nxt_st.settle = st_ff.settle - 24'h1;
                end
            end
            default: begin
                nxt_st.pwr_act = 1'b0;
                nxt_st.sq = SQ_IDLE;
            end
        endcase
        if (|trips) begin
            nxt_st.pwr_act = 1'b0;
        end
        // disabled stage: zero volts and minimum current
        nxt_st.vzero = ~nxt_st.pwr_act;
        nxt_st.imin = ~nxt_st.pwr_act;

        // read mux, prepared in the setup cycle
        if (PADDR_I == A_CTRL) begin
            rd[B_OUT] = st_ff.out_req;
            rd[B_FIEN] = st_ff.fi_en;
            rd[B_OCPEN] = st_ff.ocp_en;
        end else if (PADDR_I == A_RELAY) begin
            rd[B_RCLOSE] = st_ff.relay_tgt;
            rd[B_RPOL] = st_ff.pol_tgt;
        end else if (PADDR_I == A_DELAY) begin
            rd[14:0] = st_ff.delay_ms;
        end else if (PADDR_I == A_LINK) begin
            rd[2:0] = st_ff.linksel;
            rd[B_SRC] = 1'b1;
        end else if (PADDR_I == A_CMD || PADDR_I == A_ICLR) begin
            rd = 32'h0;
        end else if (PADDR_I == A_MEASV) begin
            rd[15:0] = st_ff.mvq;
        end else if (PADDR_I == A_MEASI) begin
            rd[15:0] = st_ff.miq;
        end else if (PADDR_I == A_STAT) begin
            rd[B_OUT] = st_ff.pwr_act;
            rd[B_SRELAY] = st_ff.relay_act;
            rd[B_SPOL] = st_ff.pol_act;
            rd[B_SOPT] = opt;
            rd[B_SPROT+3:B_SPROT] = st_ff.prot;
            rd[B_VREG] = st_ff.cond[0];
            rd[B_IREG] = st_ff.cond[1];
            rd[B_OUT_OF_REGULATION] = st_ff.cond[2];
        end else if (PADDR_I == A_ISTAT) begin
            rd[2:0] = st_ff.istat;
        end else if (PADDR_I == A_IEN) begin
            rd[2:0] = st_ff.ien;
        end else begin
            known = 1'b0;
        end
        nxt_st.pready = setup;
        // error flag stands only in the access cycle
        nxt_st.pslverr = 1'b0;
        if (setup) begin
            nxt_st.prdata = PWRITE_I ? 32'h0 : rd;
            nxt_st.pslverr = ~known | (PWRITE_I & (PADDR_I == A_STAT ||
                PADDR_I == A_ISTAT || (PADDR_I == A_RELAY & ~opt)));
        end

        // sticky interrupts; a new event wins over a clear
        if (hit_iclr) begin
            nxt_st.istat = st_ff.istat & ~PWDATA_I[2:0];
        end
        nxt_st.istat = nxt_st.istat | ev;
        nxt_st.irq = |(nxt_st.istat & nxt_st.ien);
        nxt_st.fault = nxt_st.fi_en &
            link_evt(nxt_st.linksel, nxt_st.cond, nxt_st.prot);
    end

    // ==========================================================
    // state register
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_ff <= '0;
            st_ff.delay_ms <= DELAY_RST_MS;
            st_ff.linksel <= LK_RST;
            st_ff.sq <= SQ_IDLE;
            // stage held off: zero volts, minimum current
            st_ff.vzero <= 1'b1;
            st_ff.imin <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs straight from the state register
    assign PRDATA_O = st_ff.prdata;
    assign PREADY_O = st_ff.pready;
    assign PSLVERR_O = st_ff.pslverr;
    assign POWER_EN_O = st_ff.pwr_act;
    assign VZERO_O = st_ff.vzero;
    assign ISRC_MIN_O = st_ff.imin;
    assign RELAY_CLOSE_O = st_ff.relay_act;
    assign RELAY_POL_O = st_ff.pol_act;
    assign FAULT_O = st_ff.fault;
    assign IRQ_O = st_ff.irq;

endmodule

`default_nettype wire

// *** hw/orp_pkg.sv ***
// output relay and protection control: shared constants and types
// assumes a 10 MHz core clock and an APB master with 32-bit data
package orp_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYC = CLK_HZ / MS_PER_S;
    localparam int RELAY_SETTLE_MS = 1;
    localparam int SETTLE_CYC = RELAY_SETTLE_MS * MS_CYC;
    localparam logic [14:0] DELAY_RST_MS = 15'h0064;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RELAY = 8'h04;
    localparam logic [7:0] A_DELAY = 8'h08;
    localparam logic [7:0] A_LINK = 8'h0c;
    localparam logic [7:0] A_CMD = 8'h10;
    localparam logic [7:0] A_MEASV = 8'h14;
    localparam logic [7:0] A_MEASI = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1c;
    localparam logic [7:0] A_ISTAT = 8'h20;
    localparam logic [7:0] A_ICLR = 8'h24;
    localparam logic [7:0] A_IEN = 8'h28;
    // ==========================================================
    // field positions
    localparam int B_OUT = 0;
    localparam int B_LEAVE = 1;
    localparam int B_FIEN = 2;
    localparam int B_OCPEN = 3;
    localparam int B_RCLOSE = 0;
    localparam int B_RPOL = 1;
    localparam int B_CLR = 0;
    localparam int B_SRC = 8;
    localparam int B_SRELAY = 1;
    localparam int B_SPOL = 2;
    localparam int B_SOPT = 3;
    localparam int B_SPROT = 4;
    localparam int B_VREG = 8;
    localparam int B_OUT_OF_REGULATION = 11;
    localparam int B_IREG = 10;
    // interrupt bits
    localparam int I_CMDERR = 0;
    localparam int I_TRIP = 1;
    localparam int I_COND = 2;
    // ==========================================================
    // fault indicator link selections
    localparam logic [2:0] LK_OFF = 3'h0;
    localparam logic [2:0] LK_SUMMARY_SELECTION_THREE = 3'h1;
    localparam logic [2:0] LK_IREG = 3'h2;
    localparam logic [2:0] LK_VREG = 3'h3;
    localparam logic [2:0] LK_PROT = 3'h4;
    localparam logic [2:0] LK_RST = LK_SUMMARY_SELECTION_THREE;
    // ==========================================================
    // relay sequencer states
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_DOWN = 3'b010,
        SQ_MOVE = 3'b100
    } orp_seq_t;
endpackage

// *** verification/orp_top_asserts.sv ***
// port checker for the output relay and protection block
// assumes a bind onto orp_top with the same count parameters
`timescale 1ns/1ps
`default_nettype none
module orp_top_asserts #(
    parameter int MS_CYCLES = 4,
    parameter int SETTLE_CYCLES = 3
) (
    // clock, reset and apb handshake
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // stage pins
    input wire logic RELAY_OPT_I,
    input wire logic OVTRIP_I,
    input wire logic POWER_EN_O,
    input wire logic VZERO_O,
    input wire logic ISRC_MIN_O,
    input wire logic RELAY_CLOSE_O,
    input wire logic RELAY_POL_O
);
    // ==========================================================
    // relay movement age
    logic last_close_ff;
    logic last_pol_ff;
    logic [7:0] age_ff;
    logic moved;
    assign moved = (RELAY_CLOSE_O != last_close_ff) ||
        (RELAY_POL_O != last_pol_ff);
    // cycles since the relay last moved, saturating
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            last_close_ff <= 1'b0;
            last_pol_ff <= 1'b0;
            age_ff <= 8'hff;
        end else begin
            last_close_ff <= RELAY_CLOSE_O;
            last_pol_ff <= RELAY_POL_O;
            if (moved) begin
                age_ff <= 8'h00;
            end else if (age_ff != 8'hff) begin
                age_ff <= age_ff + 8'h01;
            end
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence
    a_ready_next: assert property (s_setup |=> s_access)
        else $error("access not answered in one cycle");
    a_ready_once: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held too long");
    a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    a_vzero_off: assert property (VZERO_O == !POWER_EN_O)
        else $error("zero volt control wrong");
    a_isrc_min: assert property (ISRC_MIN_O == !POWER_EN_O)
        else $error("minimum current control wrong");
    a_relay_quiet: assert property ($changed(RELAY_CLOSE_O) |->
        !POWER_EN_O && !$past(POWER_EN_O)) else $error("relay moved live");
    a_pol_quiet: assert property ($changed(RELAY_POL_O) |->
        !POWER_EN_O && !$past(POWER_EN_O)) else $error("polarity live");
    a_settle_hold: assert property ($rose(POWER_EN_O) |->
        age_ff >= SETTLE_CYCLES - 1) else $error("power back too soon");
    a_trip_fast: assert property ($rose(OVTRIP_I) |->
        ##[1:5] !POWER_EN_O) else $error("voltage trip too slow");
    a_noopt_open: assert property (!RELAY_OPT_I &&
        !$past(RELAY_OPT_I, 3) |-> !$rose(RELAY_CLOSE_O))
        else $error("relay closed without option");
endmodule
`default_nettype wire

// *** verification/orp_stage.sv ***
// behavioural power stage facing the relay and protection block
// assumes the bench picks the load; readings are arbitrary values
`timescale 1ns/1ps
`default_nettype none
module orp_stage (
    // controls
    input wire logic power_en_i,
    input wire logic heavy_i,
    // states and readings
    output logic vreg_o,
    output logic ireg_o,
    output logic [15:0] meas_v_o,
    output logic [15:0] meas_i_o
);
    // regulation follows load; nothing while the stage is off
    assign vreg_o = power_en_i & ~heavy_i;
    assign ireg_o = power_en_i & heavy_i;
    assign meas_v_o = power_en_i ? 16'h1388 : 16'h0000;
    assign meas_i_o = power_en_i ? 16'h00c8 : 16'h0000;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the relay and protection block over apb
// assumes orp_top, orp_stage and orp_top_asserts are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb import orp_pkg::*;;
    localparam int MS = 4;
    localparam int ST = 3;
    localparam int WT = 2 * ST + 8;
    // ==========================================================
    // signals
    logic clk, nrst, psel, penable, pwrite, opt, out_of_regulation, heavy, er;
    logic [2:0] trips;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, vreg, ireg, pwr, vzero, imin, rclose, rpol;
    logic fault, irq;
    logic [15:0] mv, mi;
    logic [6:0] pins;
    int bad_count, checks_done;
    assign pins = {pwr, vzero, imin, rclose, rpol, fault, irq};
    // clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    orp_stage u_stage (.power_en_i(pwr), .heavy_i(heavy), .vreg_o(vreg),
        .ireg_o(ireg), .meas_v_o(mv), .meas_i_o(mi));
    orp_top #(.MS_CYCLES(MS), .SETTLE_CYCLES(ST)) dut (
        .CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .RELAY_OPT_I(opt), .VREG_I(vreg),
        .IREG_I(ireg), .OUT_OF_REGULATION_I(out_of_regulation), .OVTRIP_I(trips[0]),
        .THERMAL_I(trips[1]), .INHIBIT_I(trips[2]), .MEAS_V_I(mv),
        .MEAS_I_I(mi), .POWER_EN_O(pwr), .VZERO_O(vzero),
        .ISRC_MIN_O(imin), .RELAY_CLOSE_O(rclose), .RELAY_POL_O(rpol),
        .FAULT_O(fault), .IRQ_O(irq));
    // ==========================================================
    // tasks
    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait as long as it takes; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic e);
        xfer(1'b1, a, d);
        chk({31'h0, er}, {31'h0, e});
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(rd & m, x);
    endtask
    task automatic pin(input logic [6:0] m, input logic [6:0] x);
        chk({25'h0, pins & m}, {25'h0, x});
    endtask
    // ==========================================================
    // watchdog
    initial begin
        wt(20000);
        bad_count++;
        stop_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        {nrst, psel, penable, pwrite, out_of_regulation, heavy, trips} = 9'h0;
        {paddr, pwdata, opt} = {8'h0, 32'h0, 1'b1};
        bad_count = 0;
        checks_done = 0;
        wt(16);
        nrst <= 1'b1;
        pin(7'h7f, 7'h30);
        rdx(A_CTRL, 32'hffffffff, 32'h0);
        rdx(A_RELAY, 32'hffffffff, 32'h0);
        rdx(A_DELAY, 32'hffffffff, 32'h64);
        rdx(A_LINK, 32'hffffffff, 32'h101);
        wr(A_LINK, 32'h2, 1'b0);
        rdx(A_LINK, 32'hffffffff, 32'h102);
        wr(A_LINK, 32'h1, 1'b0);
        wr(A_DELAY, 32'hffff, 1'b0);
        rdx(A_DELAY, 32'hffffffff, 32'h7fff);
        wr(A_DELAY, 32'h2, 1'b0);
        rdx(A_IEN, 32'hffffffff, 32'h0);
        xfer(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, {31'h0, 1'b1});
        chk(rd, 32'h0);
        wr(A_STAT, 32'hffff, 1'b1);
        wr(A_MEASV, 32'h5, 1'b0);
        wr(A_CTRL, 32'h1, 1'b0);
        wt(WT);
        pin(7'h78, 7'h48);
        rdx(A_CTRL, 32'hffffffff, 32'h1);
        rdx(A_MEASV, 32'hffff, 32'h1388);
        rdx(A_MEASI, 32'hffff, 32'hc8);
        wr(A_CTRL, 32'h2, 1'b0);
        wt(6);
        pin(7'h78, 7'h38);
        rdx(A_CTRL, 32'hffffffff, 32'h0);
        wr(A_CTRL, 32'h3, 1'b0);
        wt(6);
        pin(7'h40, 7'h40);
        wr(A_RELAY, 32'h3, 1'b0);
        wt(2);
        pin(7'h40, 7'h00);
        wt(WT);
        pin(7'h44, 7'h44);
        wr(A_RELAY, 32'h2, 1'b0);
        wt(WT);
        rdx(A_STAT, 32'h7, 32'h5);
        wr(A_RELAY, 32'h0, 1'b0);
        wt(WT);
        pin(7'h4c, 7'h40);
        // status recording delay and its restart
        wr(A_CTRL, 32'h3, 1'b0);
        heavy <= 1'b1;
        rdx(A_STAT, 32'h500, 32'h100);
        wr(A_CTRL, 32'h3, 1'b0);
        wt(2);
        rdx(A_STAT, 32'h500, 32'h100);
        wt(40);
        rdx(A_STAT, 32'h500, 32'h400);
        // current shutdown waits for the delay
        heavy <= 1'b0;
        wt(40);
        wr(A_CTRL, 32'hb, 1'b0);
        heavy <= 1'b1;
        wt(4);
        pin(7'h40, 7'h40);
        wt(30);
        pin(7'h43, 7'h00);
        rdx(A_STAT, 32'hf0, 32'h20);
        rdx(A_ISTAT, 32'h2, 32'h2);
        wr(A_IEN, 32'h2, 1'b0);
        wt(2);
        pin(7'h01, 7'h01);
        wr(A_ICLR, 32'h2, 1'b0);
        wt(2);
        pin(7'h01, 7'h00);
        wr(A_CTRL, 32'hf, 1'b0);
        wt(3);
        pin(7'h02, 7'h02);
        heavy <= 1'b0;
        wt(40);
        wr(A_CMD, 32'h1, 1'b0);
        wt(4);
        pin(7'h42, 7'h40);
        // each pin-driven latched trip (voltage, thermal, inhibit), then a clear
        for (int i = 0; i < 3; i++) begin
            trips <= 3'(1 << i);
            wt(8);
            pin(7'h42, 7'h02);
            rdx(A_STAT, 32'hf0, (i == 0) ? 32'h10 : 32'h20 << i);
            trips <= 3'h0;
            wr(A_CMD, 32'h1, 1'b0);
            wt(4);
            pin(7'h40, 7'h40);
        end
        out_of_regulation <= 1'b1;
        wt(40);
        pin(7'h02, 7'h02);
        wr(A_LINK, 32'h2, 1'b0);
        wt(3);
        pin(7'h02, 7'h00);
        wr(A_LINK, 32'h3, 1'b0);
        wt(3);
        pin(7'h02, 7'h02);
        wr(A_LINK, 32'h0, 1'b0);
        wt(3);
        pin(7'h02, 7'h00);
        out_of_regulation <= 1'b0;
        wr(A_CTRL, 32'h1, 1'b0);
        wt(WT);
        pin(7'h48, 7'h48);
        wr(A_CTRL, 32'h0, 1'b0);
        wt(WT);
        pin(7'h78, 7'h30);
        opt <= 1'b0;
        wt(4);
        wr(A_RELAY, 32'h1, 1'b1);
        rdx(A_ISTAT, 32'h1, 32'h1);
        wr(A_CTRL, 32'h1, 1'b0);
        wt(WT);
        pin(7'h48, 7'h40);
        stop_test();
    end
endmodule
bind orp_top orp_top_asserts #(.MS_CYCLES(MS_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.CORE_CLK_I, .NRST_I, .PSEL_I,
    .PENABLE_I, .PREADY_O, .PSLVERR_O, .RELAY_OPT_I, .OVTRIP_I,
    .POWER_EN_O, .VZERO_O, .ISRC_MIN_O, .RELAY_CLOSE_O, .RELAY_POL_O);
`default_nettype wire
